//--- rtl/cmp_cond.sv
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
module cmp_cond (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Avalon-MM slave
  input  wire logic [1:0] address,
  input  wire logic       read,
  input  wire logic       write,
  input  wire logic [3:0] byteenable,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output logic            waitrequest,
  // Analog front end
  input  wire logic       raw_compare,
  output logic            compare_enable,
  output logic            hysteresis_en,
  // Timer partner
  input  wire logic       timer_clk_src,
  input  wire logic       timer_prescaled,
  input  wire logic       timer_prescale_on,
  output logic            timer_gate_out,
  output logic            compare_pin_out,
  // Flag
  output logic            compare_irq_flag
);
  import cmp_cond_pkg::*;

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic       sync_en;
  logic       reversal_hold_filter_en;
  logic       output_invert;
  logic [1:0] edge_en;
  logic       rise_flag_en;
  logic       fall_flag_en;
  logic       flag;
  logic       raw_sync;
  logic       gated;
  logic       inverted;
  logic       filtered;
  logic       latch_clk;
  logic       latch_clk_q;
  logic       held;
  logic       external;
  logic [1:0] instr_cnt;
  logic       instr_tick;
  logic       compare_result;
  logic       result_q;
  logic       rise_det;
  logic       fall_det;
  logic       flag_set;
  logic       wr_main;
  logic       wr_edge;
  logic       wr_flag;
  logic       ack_pending;

  // Edge enable bits split by meaning
  assign rise_flag_en = edge_en[rise_bit - fall_bit];
  assign fall_flag_en = edge_en[0];

  // ************************************************************
  // Avalon slave
  // ************************************************************
  // One wait state on every access, then the answer
  assign waitrequest = (read | write) & ~ack_pending;
  assign wr_main = write & ack_pending & byteenable[0] & (address == main_ctrl_addr);
  assign wr_edge = write & ack_pending & byteenable[0] & (address == edge_ctrl_addr);
  assign wr_flag = write & ack_pending & byteenable[0] & (address == flag_addr);

  // Wait state tracker
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_pending <= 1'b0;
    end else begin
      ack_pending <= (read | write) & ~ack_pending;
    end
  end

  // Control register writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compare_enable          <= main_ctrl_reset[enable_bit];
      output_invert           <= main_ctrl_reset[inv_bit];
      reversal_hold_filter_en <= main_ctrl_reset[filt_bit];
      hysteresis_en           <= main_ctrl_reset[hyst_bit];
      sync_en                 <= main_ctrl_reset[sync_bit];
      edge_en                 <= edge_ctrl_reset;
    end else begin
      if (wr_main) begin
        compare_enable          <= writedata[enable_bit];
        output_invert           <= writedata[inv_bit];
        reversal_hold_filter_en <= writedata[filt_bit];
        hysteresis_en           <= writedata[hyst_bit];
        sync_en                 <= writedata[sync_bit];
      end
      if (wr_edge) begin
        edge_en <= writedata[rise_bit:fall_bit];
      end
    end
  end

  // Read data, registered at the edge that ends the wait state; unmapped reads zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_pending) begin
      readdata <= 32'h0000_0000;
      unique case (address)
        main_ctrl_addr: begin
          readdata[enable_bit] <= compare_enable;
          readdata[result_bit] <= compare_result;
          readdata[resv_hi]    <= 1'b1;
          readdata[inv_bit]    <= output_invert;
          readdata[filt_bit]   <= reversal_hold_filter_en;
          readdata[resv_lo]    <= 1'b1;
          readdata[hyst_bit]   <= hysteresis_en;
          readdata[sync_bit]   <= sync_en;
        end
        edge_ctrl_addr: readdata[rise_bit:fall_bit] <= edge_en;
        flag_addr:      readdata[0] <= flag;
        default:        readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Result path
  // ************************************************************
  sync2 u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (raw_compare),
    .dout   (raw_sync)
  );

  // Inputs disconnected when off; result then idles low before inversion
  assign gated    = compare_enable & raw_sync;
  assign inverted = gated ^ output_invert;

  hold_filter u_filt (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (reversal_hold_filter_en),
    .din    (inverted),
    .dout   (filtered)
  );

  // Latch strobe: prescaled clock when the prescaler is in use
  assign latch_clk = timer_prescale_on ? timer_prescaled : timer_clk_src;

  // Falling edge capture of the timer latch clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_clk_q <= 1'b0;
      held        <= 1'b0;
    end else begin
      latch_clk_q <= latch_clk;
      if (latch_clk_q & ~latch_clk) begin
        held <= filtered;
      end
    end
  end

  // External routing: held value under sync, else direct
  assign external        = sync_en ? held : filtered;
  assign timer_gate_out  = external;
  assign compare_pin_out = external;

  // Instruction cycle tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_cnt <= 2'h0;
    end else begin
      instr_cnt <= (instr_cnt == instr_last) ? 2'h0 : instr_cnt + 2'h1;
    end
  end
  assign instr_tick = (instr_cnt == instr_last);

  // Internal result registered once per instruction cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compare_result <= 1'b0;
    end else if (instr_tick) begin
      compare_result <= filtered;
    end
  end

  // ************************************************************
  // Edge detection and flag
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= 1'b0;
    end else begin
      result_q <= compare_result;
    end
  end

  assign rise_det = compare_result & ~result_q;
  assign fall_det = ~compare_result & result_q;
  assign flag_set = (rise_det & rise_flag_en) | (fall_det & fall_flag_en);

  // Sticky flag; software writes 1 to bit 0 to clear, set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (wr_flag & writedata[0]) begin
      flag <= 1'b0;
    end
  end
  assign compare_irq_flag = flag;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Flag set, hold and clear priority
  flag_sets_a: assert property (flag_set |=> flag)
    else $error("flag not set after enabled edge");
  set_wins_a: assert property (flag_set && wr_flag |=> flag)
    else $error("clear beat a simultaneous set");
  flag_sticky_a: assert property (flag && !wr_flag |=> flag)
    else $error("flag dropped without software clear");

  // Edge masks
  rise_masked_a: assert property (rise_det && !rise_flag_en && !fall_flag_en && !flag
                                  |=> !flag)
    else $error("flag set by disabled edge");

  // Synchronised capture and direct route
  held_stable_a: assert property (sync_en && !(latch_clk_q && !latch_clk)
                                  |=> $stable(held))
    else $error("held value changed without falling edge");
  sync_route_a: assert property (!sync_en |-> compare_pin_out == filtered)
    else $error("direct route broken");

  // Polarity and filter
  invert_a: assert property (!reversal_hold_filter_en
                             |=> filtered == (($past(raw_sync) & $past(compare_enable))
                                              ^ $past(output_invert)))
    else $error("inversion wrong");
  hold_rev_a: assert property (reversal_hold_filter_en && $changed(filtered)
                               && $past(reversal_hold_filter_en) |=> $stable(filtered))
    else $error("reversal within hold time");

  // Off comparator and instruction tick
  off_gate_a: assert property (!compare_enable && !reversal_hold_filter_en
                               |=> filtered == $past(output_invert))
    else $error("input not disconnected when off");
  result_tick_a: assert property (!instr_tick |=> $stable(compare_result))
    else $error("internal result moved between ticks");

  // ************************************************************
  // Bus and register checks
  // ************************************************************
  // First cycle of every access is stalled, the second answers
  wait_first_a: assert property ((read || write) && !ack_pending |-> waitrequest)
    else $error("access not stalled in its first cycle");
  answer_next_a: assert property ((read || write) && !ack_pending |=> !waitrequest)
    else $error("access not answered in its second cycle");

  // Register writes land at the answering edge
  edge_write_a: assert property (wr_edge |=> edge_en == $past(writedata[rise_bit:fall_bit]))
    else $error("edge control write lost");
  enable_write_a: assert property (wr_main |=> compare_enable == $past(writedata[enable_bit]))
    else $error("enable write lost");
  hyst_write_a: assert property (wr_main |=> hysteresis_en == $past(writedata[hyst_bit]))
    else $error("hysteresis write lost");
  invert_write_a: assert property (wr_main |=> output_invert == $past(writedata[inv_bit]))
    else $error("polarity write lost");
  filter_write_a: assert property (wr_main
                                   |=> reversal_hold_filter_en == $past(writedata[filt_bit]))
    else $error("filter enable write lost");
  sync_write_a: assert property (wr_main |=> sync_en == $past(writedata[sync_bit]))
    else $error("sync write lost");

  // Main control reads: reserved bits one, result bit the internal result
  resv_read_a: assert property (read && !ack_pending && address == main_ctrl_addr
                                |=> readdata[resv_hi] && readdata[resv_lo])
    else $error("reserved bit read as zero");
  result_read_a: assert property (read && !ack_pending && address == main_ctrl_addr
                                  |=> readdata[result_bit] == $past(compare_result))
    else $error("result bit read wrong");

  // ************************************************************
  // Result path checks
  // ************************************************************
  // Synchroniser delays the pin by two edges outside reset
  sync_delay_a: assert property ($past(arst_n) && $past(arst_n, 2)
                                 |-> raw_sync == $past(raw_compare, 2))
    else $error("synchroniser delay wrong");

  // Capture takes the conditioned value on a latch clock fall
  latch_take_a: assert property (latch_clk_q && !latch_clk |=> held == $past(filtered))
    else $error("falling edge capture missed");

  // Internal result samples the conditioned value at each tick
  result_take_a: assert property (instr_tick |=> compare_result == $past(filtered))
    else $error("internal result missed its tick");

  // Edge detectors see every move of the internal result
  rise_det_a: assert property ($rose(compare_result) |-> rise_det)
    else $error("rising edge not detected");
  fall_det_a: assert property ($fell(compare_result) |-> fall_det)
    else $error("falling edge not detected");

  // Flag only ever rises because of an enabled edge
  flag_cause_a: assert property ($rose(flag) |-> $past(flag_set))
    else $error("flag set without an enabled edge");

  // ************************************************************
  // Scenario covers
  // ************************************************************
  // Main scenarios the bench is expected to reach
  rise_seen_c: cover property (rise_det && rise_flag_en);
  fall_seen_c: cover property (fall_det && fall_flag_en);
  clear_race_c: cover property (flag_set && wr_flag);
  sync_latch_c: cover property (sync_en && latch_clk_q && !latch_clk);
  filter_hold_c: cover property (reversal_hold_filter_en && $changed(filtered));
endmodule // cmp_cond
`default_nettype wire

//--- rtl/cmp_cond_pkg.sv
`default_nettype none
package cmp_cond_pkg;
  // ************************************************************
  // Register map (word addresses on the Avalon bus)
  // ************************************************************
  localparam logic [1:0] main_ctrl_addr = 2'h0;
  localparam logic [1:0] edge_ctrl_addr = 2'h1;
  localparam logic [1:0] flag_addr      = 2'h2;

  // Main control field positions
  localparam int sync_bit   = 0;
  localparam int hyst_bit   = 1;
  localparam int resv_lo    = 2;
  localparam int filt_bit   = 3;
  localparam int inv_bit    = 4;
  localparam int resv_hi    = 5;
  localparam int result_bit = 6;
  localparam int enable_bit = 7;

  // Edge control field positions
  localparam int fall_bit = 0;
  localparam int rise_bit = 1;

  // Values after reset
  localparam logic [7:0] main_ctrl_reset = 8'h24;
  localparam logic [1:0] edge_ctrl_reset = 2'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int clock_mhz     = 25;
  localparam int hold_time_ns  = 20;
  // Least time rounds up, never below one cycle
  localparam int hold_cycles_raw = (hold_time_ns * clock_mhz + 999) / 1000;
  localparam int hold_cycles     = (hold_cycles_raw < 1) ? 1 : hold_cycles_raw;
  // Instruction cycle enable every four clocks
  localparam int instr_div       = 4;
  localparam logic [1:0] instr_last = 2'(instr_div - 1);
endpackage
`default_nettype wire

//--- rtl/hold_filter.sv
`default_nettype none
module hold_filter (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Control and data
  input  wire logic enable,
  input  wire logic din,
  output var  logic dout
);
  import cmp_cond_pkg::*;

  logic [3:0] hold_cnt;

  // Blocks a reversal while the hold count runs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dout     <= 1'b0;
      hold_cnt <= 4'h0;
    end else if (!enable) begin
      dout     <= din;
      hold_cnt <= 4'h0;
    end else if (hold_cnt != 4'h0) begin
      hold_cnt <= hold_cnt - 4'h1;
    end else if (din != dout) begin
      dout     <= din;
      hold_cnt <= 4'(hold_cycles);
    end
  end
endmodule // hold_filter
`default_nettype wire

//--- rtl/sync2.sv
`default_nettype none
module sync2 (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Data
  input  wire logic din,
  output var  logic dout
);
  logic stage1;

  // Two flip-flop synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sync2
`default_nettype wire

//--- test/comparator_output_conditioning_tb.sv
`default_nettype none
// ************************************************************
// Bench for the comparator conditioning block
// ************************************************************
module comparator_output_conditioning_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_cond_pkg::*;
  logic        clock, arst_n, read, write, raw_compare, t_run, t_pre, pre_on;
  logic [1:0]  address;
  logic [31:0] writedata, readdata;
  logic        waitrequest, compare_enable, hysteresis_en, t_src, t_div;
  logic        timer_gate_out, compare_pin_out, compare_irq_flag;
  int          n_mismatch, checks;

  // Clock of 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Block under test and its timer partner
  cmp_cond DUT (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .raw_compare(raw_compare),
    .compare_enable(compare_enable), .hysteresis_en(hysteresis_en),
    .timer_clk_src(t_src), .timer_prescaled(t_div), .timer_prescale_on(pre_on),
    .timer_gate_out(timer_gate_out), .compare_pin_out(compare_pin_out),
    .compare_irq_flag(compare_irq_flag));
  timer_model tmr (.clock(clock), .arst_n(arst_n), .run(t_run), .pre_run(t_pre),
    .src(t_src), .prescaled(t_div), .count());

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= ~wr;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, q);
    check(what, exp, q[7:0]);
  endtask

  task automatic raw(input logic v);
    @(posedge clock);
    raw_compare <= v;
    wait_n(16);
  endtask

  task automatic tick(input int n);
    @(posedge clock);
    t_run <= 1'b1;
    wait_n(n);
    t_run <= 1'b0;
    wait_n(4);
  endtask

  task automatic t_regs;
    rd_chk("main reset", main_ctrl_addr, 8'h24);
    rd_chk("edge reset", edge_ctrl_addr, 8'h00);
    rd_chk("unmapped", 2'h3, 8'h00);
    wr(main_ctrl_addr, 8'ha6);
    rd_chk("main rw", main_ctrl_addr, 8'ha6);
    check("enable out", 8'h1, 8'(compare_enable));
    check("hyst out", 8'h1, 8'(hysteresis_en));
    wr(main_ctrl_addr, 8'h24);
    wait_n(1);
    check("enable off", 8'h0, 8'(compare_enable));
    $display("test regs done");
  endtask

  task automatic t_polarity;
    wr(main_ctrl_addr, 8'ha4);
    raw(1'b1);
    rd_chk("result", main_ctrl_addr, 8'he4);
    check("pin", 8'h1, 8'(compare_pin_out));
    check("gate", 8'h1, 8'(timer_gate_out));
    wr(main_ctrl_addr, 8'hb4);
    wait_n(16);
    rd_chk("inverted", main_ctrl_addr, 8'hb4);
    check("pin inv", 8'h0, 8'(compare_pin_out));
    $display("test polarity done");
  endtask

  task automatic t_edges;
    logic [1:0] c;
    wr(main_ctrl_addr, 8'ha4);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      raw(1'b0);
      wr(edge_ctrl_addr, {6'h0, c});
      rd_chk("edge rw", edge_ctrl_addr, {6'h0, c});
      wr(flag_addr, 8'h01);
      raw(1'b1);
      check("rise flag", 8'(c[rise_bit]), 8'(compare_irq_flag));
      wait_n(40);
      check("flag held", 8'(c[rise_bit]), 8'(compare_irq_flag));
      wr(flag_addr, 8'h01);
      raw(1'b0);
      check("fall flag", 8'(c[fall_bit]), 8'(compare_irq_flag));
      rd_chk("flag reg", flag_addr, {7'h0, c[fall_bit]});
    end
    $display("test edges done");
  endtask

  task automatic t_disabled;
    wr(main_ctrl_addr, 8'h24);
    wr(edge_ctrl_addr, 8'h03);
    wait_n(16);
    wr(flag_addr, 8'h01);
    wr(main_ctrl_addr, 8'h34);
    wait_n(16);
    check("invert edge", 8'h1, 8'(compare_irq_flag));
    $display("test disabled done");
  endtask

  // One-cycle pulse: stretched by the hold time when filtered, passed as is otherwise
  task automatic t_filter;
    int hi;
    wr(main_ctrl_addr, 8'hac);
    raw(1'b0);
    for (int f = 1; f >= 0; f--) begin
      hi = 0;
      @(posedge clock);
      raw_compare <= 1'b1;
      @(posedge clock);
      raw_compare <= 1'b0;
      repeat (12) begin
        @(posedge clock);
        if (compare_pin_out === 1'b1) hi++;
      end
      check("pulse width", 8'((f != 0) ? hold_cycles + 1 : 1), 8'(hi));
      wr(main_ctrl_addr, 8'ha4);
    end
    $display("test filter done");
  endtask

  task automatic t_sync;
    wr(main_ctrl_addr, 8'ha5);
    raw(1'b0);
    tick(24);
    raw(1'b1);
    check("sync held", 8'h0, 8'(compare_pin_out));
    tick(24);
    check("sync latched", 8'h1, 8'(compare_pin_out));
    pre_on <= 1'b1;
    raw(1'b0);
    tick(24);
    check("pre held", 8'h1, 8'(timer_gate_out));
    t_pre <= 1'b1;
    tick(40);
    check("pre latched", 8'h0, 8'(timer_gate_out));
    $display("test sync done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 2'h0;
    writedata = 32'h0;
    raw_compare = 1'b0;
    t_run = 1'b0;
    t_pre = 1'b0;
    pre_on = 1'b0;
    wait_n(2);
    arst_n <= 1'b1;
    t_regs();
    t_polarity();
    t_edges();
    t_disabled();
    t_filter();
    t_sync();
    end_of_test();
  end

  // Watchdog well beyond the run length
  initial begin
    wait_n(20000);
    n_mismatch++;
    end_of_test();
  end
endmodule // comparator_output_conditioning_tb
`default_nettype wire

//--- test/timer_model.sv
`default_nettype none
// ************************************************************
// Timer partner: source clock, prescaler and counter
// ************************************************************
module timer_model (
  // Clock and control
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic       pre_run,
  // Timer clocks and count
  output logic            src,
  output logic            prescaled,
  output logic [7:0]      count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;

  // Source clock stands still while stopped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div <= 2'h0;
      src <= 1'b0;
    end else if (run) begin
      div <= div + 2'h1;
      if (div == 2'h3) src <= ~src;
    end
  end

  // Count and prescaler both advance on the rising edge only
  always_ff @(posedge src or negedge arst_n) begin
    if (!arst_n) begin
      prescaled <= 1'b0;
      count     <= 8'h0;
    end else begin
      count <= count + 8'h1;
      if (pre_run) prescaled <= ~prescaled;
    end
  end
endmodule // timer_model
`default_nettype wire
